// [verilog/csr_engine.sv]
// Function
// - clear faults wipes status, drops alert
// - clearing never restarts latched-off supplies
// - persisting fault relatches without new alert
// - protect level gates which writes pass
// - blocked writes vanish silently
// - reads always served despite protection
// - accepted writes touch working RAM only
// - store default copies RAM into main
// - failed store sets CML, alerts if enabled
// - whole-array store blocks commands, halts monitoring
// - default restore validates, falls back to backup
// - both corrupt: null state, fault pins asserted
// - reset runs default restore automatically
// - vendor store: code 0 main, 1 backup
// - vendor restore: code 0 main, 1 backup
// - vendor restore flags corruption, no fallback
// - single store word: page high, command low
// - single store read returns last stored word
// - crc select picks reported array crc
// - no select written: crc reads FFFFh
`timescale 1ns/1ps
module csr_engine #(
    parameter logic [15:0] PROG_CYCLES = csr_pkg::PROG_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire csr_pkg::csr_cmd_t cmd_i,
    output csr_pkg::csr_rsp_t rsp_o,
    output logic cmd_ready_o,
    output csr_pkg::csr_ram_wr_t ram_wr_o,
    output csr_pkg::csr_flash_req_t flash_req_o,
    input wire logic flash_done_i,
    input wire logic flash_err_i,
    input wire logic main_ok_i,
    input wire logic backup_ok_i,
    input wire logic [15:0] crc_main_i,
    input wire logic [15:0] crc_backup_i,
    input wire logic [15:0] crc_ram_i,
    input wire logic [csr_pkg::NUM_FAULTS-1:0] fault_event_i,
    input wire logic alert_en_i,
    output logic [csr_pkg::NUM_FAULTS-1:0] status_fault_o,
    output logic alert_o,
    output logic cml_o,
    output logic [7:0] cml_detail_o,
    output logic monitor_hold_o,
    output logic null_state_o,
    output logic fault_pin_n_o
);
    import csr_pkg::*;

    function automatic logic wp_allows(input logic [7:0] lvl, input logic [7:0] code);
        logic self_ok;
        logic op_ok;
        self_ok = (code == CMD_WRITE_PROTECT);
        op_ok = self_ok || (code == CMD_OPERATION) || (code == CMD_PAGE);
        case (lvl)
            WP_ONLY_SELF: wp_allows = self_ok;
            WP_OP_PAGE: wp_allows = op_ok;
            WP_ON_OFF: wp_allows = op_ok || (code == CMD_ON_OFF_CONFIG);
            default: wp_allows = 1'b1;
        endcase
    endfunction

    function automatic csr_flash_req_t mk_req(input logic store, input logic [1:0] arr,
                                              input logic [15:0] data);
        mk_req = '{start: 1'b1, store: store, arr: arr, data: data};
    endfunction

    csr_state_t state_q, state_d;
    csr_rmode_t rmode_q, rmode_d;
    csr_flash_req_t req_q, req_d;
    logic [7:0] wp_q;
    logic [15:0] single_q;
    logic [15:0] crc_sel_q;
    logic crc_vld_q;
    logic [15:0] cnt_q;
    logic done_seen_q;
    logic err_seen_q;
    logic [NUM_FAULTS-1:0] fault_prev_q;
    logic null_q;
    logic [1:0] det_set;
    logic null_set;

    // command decode
    wire cmd_go = ce_i && cmd_i.valid && cmd_ready_o;
    wire wr_go = cmd_go && cmd_i.write;
    wire rd_go = cmd_go && !cmd_i.write;
    wire wr_ok = wr_go && wp_allows(wp_q, cmd_i.code);
    wire [7:0] code_byte = cmd_i.data[7:0];
    wire is_clr = (cmd_i.code == CMD_CLEAR_FAULTS);
    wire is_wp = (cmd_i.code == CMD_WRITE_PROTECT);
    wire is_sda = (cmd_i.code == CMD_STORE_DEFAULT);
    wire is_rda = (cmd_i.code == CMD_RESTORE_DEFAULT);
    wire is_vsa = (cmd_i.code == CMD_VENDOR_STORE_ALL);
    wire is_vra = (cmd_i.code == CMD_VENDOR_RESTORE_ALL);
    wire is_single = (cmd_i.code == CMD_SINGLE_PARAM_STORE);
    wire is_crc = (cmd_i.code == CMD_CRC_REPORT);
    wire is_engine = is_clr || is_sda || is_rda || is_vsa || is_vra || is_single || is_crc;

    wire wr_clear = wr_ok && is_clr;
    // other code bytes fall through to nothing
    wire store_main = wr_ok && (is_sda || (is_vsa && code_byte == CODE_MAIN));
    wire store_bk = wr_ok && is_vsa && (code_byte == CODE_BACKUP);
    wire store_single = wr_ok && is_single;
    wire rest_def = wr_ok && is_rda;
    wire rest_main = wr_ok && is_vra && (code_byte == CODE_MAIN);
    wire rest_bk = wr_ok && is_vra && (code_byte == CODE_BACKUP);

    // transfer completion; done may come early, so it is latched
    wire done_now = done_seen_q || flash_done_i;
    wire err_now = done_seen_q ? err_seen_q : flash_err_i;
    wire xfer_end = (state_q == ST_XFER) && (cnt_q == 16'h0000) && done_now;
    wire store_fail = xfer_end && req_q.store && err_now;
    wire single_ok = xfer_end && req_q.store && !err_now && (req_q.arr == ARR_SINGLE);

    // status and alert
    wire [NUM_FAULTS-1:0] fault_new = fault_event_i & ~fault_prev_q;
    wire alert_set = alert_en_i && ((|fault_new) || store_fail);

    always_comb begin
        state_d = state_q;
        rmode_d = rmode_q;
        req_d = req_q;
        req_d.start = 1'b0;
        det_set = 2'b00;
        null_set = 1'b0;
        case (state_q)
            ST_BOOT: begin
                state_d = ST_CHK;
                rmode_d = RM_DEFAULT;
            end
            ST_IDLE: begin
                if (store_main || store_bk || store_single) begin
                    state_d = ST_XFER;
                    req_d = mk_req(1'b1, store_single ? ARR_SINGLE :
                                   (store_bk ? ARR_BACKUP : ARR_MAIN), cmd_i.data);
                end else if (rest_def || rest_main || rest_bk) begin
                    state_d = ST_CHK;
                    rmode_d = rest_def ? RM_DEFAULT : (rest_main ? RM_MAIN : RM_BACKUP);
                end
            end
            ST_CHK: begin
                state_d = ST_XFER;
                case (rmode_q)
                    RM_DEFAULT: begin
                        if (main_ok_i) begin
                            req_d = mk_req(1'b0, ARR_MAIN, 16'h0000);
                        end else if (backup_ok_i) begin
                            det_set = 2'b01;
                            req_d = mk_req(1'b0, ARR_BACKUP, 16'h0000);
                        end else begin
                            det_set = 2'b11;
                            null_set = 1'b1;
                            state_d = ST_IDLE;
                        end
                    end
                    RM_MAIN: begin
                        if (main_ok_i) begin
                            req_d = mk_req(1'b0, ARR_MAIN, 16'h0000);
                        end else begin
                            det_set = 2'b01;
                            state_d = ST_IDLE;
                        end
                    end
                    default: begin
                        if (backup_ok_i) begin
                            req_d = mk_req(1'b0, ARR_BACKUP, 16'h0000);
                        end else begin
                            det_set = 2'b10;
                            state_d = ST_IDLE;
                        end
                    end
                endcase
            end
            ST_XFER: begin
                if (xfer_end) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // single stores leave monitoring running so supplies can be operated
    wire hold_d = (state_d != ST_IDLE) &&
                  !((state_d == ST_XFER) && (req_d.arr == ARR_SINGLE));
    wire [15:0] cnt_d = (state_q != ST_XFER) ? PROG_CYCLES - 16'h0001 :
                        ((cnt_q != 16'h0000) ? cnt_q - 16'h0001 : 16'h0000);

    wire [15:0] crc_pick = (crc_sel_q == CRC_SEL_MAIN) ? crc_main_i :
                           (crc_sel_q == CRC_SEL_BACKUP) ? crc_backup_i :
                           (crc_sel_q == CRC_SEL_RAM) ? crc_ram_i : CRC_NONE;
    wire [15:0] rd_data = is_wp ? {8'h00, wp_q} :
                          is_single ? single_q :
                          is_crc ? (crc_vld_q ? crc_pick : CRC_NONE) : 16'h0000;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_BOOT;
            rmode_q <= RM_DEFAULT;
            req_q <= '0;
            cnt_q <= 16'h0000;
            done_seen_q <= 1'b0;
            err_seen_q <= 1'b0;
        end else if (ce_i) begin
            state_q <= state_d;
            rmode_q <= rmode_d;
            req_q <= req_d;
            cnt_q <= cnt_d;
            done_seen_q <= (state_q == ST_XFER) && !xfer_end && done_now;
            err_seen_q <= done_seen_q ? err_seen_q : flash_err_i;
        end
    end

    // busy gates the decoder for the whole programming time
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_ready_o <= 1'b0;
            monitor_hold_o <= 1'b1;
        end else if (ce_i) begin
            cmd_ready_o <= (state_d == ST_IDLE);
            monitor_hold_o <= hold_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_q <= WP_RESET;
            single_q <= SINGLE_RESET;
            crc_sel_q <= CRC_SEL_MAIN;
            crc_vld_q <= 1'b0;
        end else if (ce_i) begin
            if (wr_ok && is_wp) begin
                wp_q <= code_byte;
            end
            if (single_ok) begin
                single_q <= req_q.data;
            end
            if (wr_ok && is_crc) begin
                crc_sel_q <= cmd_i.data;
                crc_vld_q <= 1'b1;
            end
        end
    end

    // blocked writes simply never reach RAM; no flag anywhere
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ram_wr_o <= '0;
            rsp_o <= '0;
            flash_req_o <= '0;
        end else if (ce_i) begin
            ram_wr_o <= '{valid: wr_ok && !is_engine, code: cmd_i.code,
                          data: cmd_i.data};
            rsp_o <= '{valid: rd_go, data: rd_data};
            flash_req_o <= req_d;
        end
    end

    // clear touches only status, alert, cml and cml detail; supply enables live elsewhere
    // a set in the clear cycle wins so no event is lost
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_fault_o <= '0;
            fault_prev_q <= '0;
            alert_o <= 1'b0;
            cml_o <= 1'b0;
            cml_detail_o <= 8'h00;
        end else if (ce_i) begin
            fault_prev_q <= fault_event_i;
            status_fault_o <= wr_clear ? fault_event_i
                                       : (status_fault_o | fault_event_i);
            alert_o <= alert_set ? 1'b1 : (wr_clear ? 1'b0 : alert_o);
            cml_o <= store_fail ? 1'b1 : (wr_clear ? 1'b0 : cml_o);
            cml_detail_o[DET_MAIN_BAD] <= det_set[0] || (!wr_clear && cml_detail_o[DET_MAIN_BAD]);
            cml_detail_o[DET_BACKUP_BAD] <= det_set[1] ||
                                            (!wr_clear && cml_detail_o[DET_BACKUP_BAD]);
        end
    end

    // null state holds until the next reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            null_q <= 1'b0;
            null_state_o <= 1'b0;
            fault_pin_n_o <= 1'b1;
        end else if (ce_i) begin
            null_q <= null_q || null_set;
            null_state_o <= null_q || null_set;
            fault_pin_n_o <= !(null_q || null_set);
        end
    end

    clear_drops_alert_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && wr_clear && !alert_set |=> !alert_o && status_fault_o == $past(fault_event_i))
        else $error("alert or status not cleared by clear faults");

    persist_no_alert_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && wr_clear && !alert_set) ##1 (!alert_set) |=> !alert_o)
        else $error("persisting fault reasserted alert");

    protect_block_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && wr_go && wp_q == WP_ONLY_SELF && !is_wp |=> !ram_wr_o.valid && !flash_req_o.start)
        else $error("protected write got through");

    blocked_silent_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && wr_go && !wr_ok |=> $stable(cml_o) && $stable(cml_detail_o))
        else $error("blocked write raised status");

    read_served_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && rd_go |=> rsp_o.valid)
        else $error("read not answered");

    store_fail_cml_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && store_fail |=> cml_o && cml_detail_o == $past(cml_detail_o))
        else $error("store failure not flagged correctly");

    store_busy_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && state_q == ST_IDLE && (store_main || store_bk)
        |=> !cmd_ready_o && monitor_hold_o && flash_req_o.start && flash_req_o.store)
        else $error("whole-array store did not go busy");

    busy_full_time_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state_q == ST_XFER && cnt_q != 16'h0000 |-> !cmd_ready_o && !xfer_end)
        else $error("transfer ended before programming time");

    null_both_bad_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && state_q == ST_CHK && rmode_q == RM_DEFAULT && !main_ok_i && !backup_ok_i
        |=> null_state_o && !fault_pin_n_o && cml_detail_o[2:1] == 2'b11)
        else $error("both arrays bad without null state");

    fallback_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && state_q == ST_CHK && rmode_q == RM_DEFAULT && !main_ok_i && backup_ok_i
        |=> flash_req_o.start && flash_req_o.arr == ARR_BACKUP && cml_detail_o[1])
        else $error("no fallback to backup array");

    vendor_no_fallback_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && state_q == ST_CHK && rmode_q == RM_MAIN && !main_ok_i
        |=> !flash_req_o.start && $stable(null_state_o) && state_q == ST_IDLE && cml_detail_o[1])
        else $error("vendor restore took fallback");

    boot_restore_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && state_q == ST_BOOT |=> state_q == ST_CHK && rmode_q == RM_DEFAULT)
        else $error("reset did not start default restore");

    crc_default_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && rd_go && is_crc && !crc_vld_q |=> rsp_o.data == CRC_NONE)
        else $error("crc read without select not FFFFh");

    single_word_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && single_ok |=> single_q == $past(req_q.data) && !monitor_hold_o)
        else $error("single store word not recorded");

endmodule // csr_engine

// [shared/csr_pkg.sv]
package csr_pkg;

    // command codes seen by this engine
    localparam logic [7:0] CMD_PAGE = 8'h00;
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_WRITE_PROTECT = 8'h10;
    localparam logic [7:0] CMD_STORE_DEFAULT = 8'h11;
    localparam logic [7:0] CMD_RESTORE_DEFAULT = 8'h12;
    localparam logic [7:0] CMD_VENDOR_STORE_ALL = 8'hEE;
    localparam logic [7:0] CMD_VENDOR_RESTORE_ALL = 8'hEF;
    localparam logic [7:0] CMD_SINGLE_PARAM_STORE = 8'hFC;
    localparam logic [7:0] CMD_CRC_REPORT = 8'hFE;

    // write protection levels
    localparam logic [7:0] WP_ONLY_SELF = 8'h80;
    localparam logic [7:0] WP_OP_PAGE = 8'h40;
    localparam logic [7:0] WP_ON_OFF = 8'h20;
    localparam logic [7:0] WP_RESET = 8'h00;

    // code byte of vendor store/restore
    localparam logic [7:0] CODE_MAIN = 8'h00;
    localparam logic [7:0] CODE_BACKUP = 8'h01;

    // crc report select codes
    localparam logic [15:0] CRC_SEL_MAIN = 16'h0000;
    localparam logic [15:0] CRC_SEL_BACKUP = 16'h0001;
    localparam logic [15:0] CRC_SEL_RAM = 16'h0002;
    localparam logic [15:0] CRC_NONE = 16'hFFFF;

    // detailed communication status bit positions
    localparam int DET_MAIN_BAD = 1;
    localparam int DET_BACKUP_BAD = 2;

    // flash arrays
    localparam logic [1:0] ARR_MAIN = 2'h0;
    localparam logic [1:0] ARR_BACKUP = 2'h1;
    localparam logic [1:0] ARR_SINGLE = 2'h2;

    localparam int NUM_FAULTS = 8;
    localparam logic [15:0] SINGLE_RESET = 16'h0000;

    // flash programming hold time
    localparam int CLK_PERIOD_NS = 5;
    localparam int PROG_TIME_NS = 10000;
    localparam logic [15:0] PROG_CYCLES_DEF = 16'(PROG_TIME_NS / CLK_PERIOD_NS);

    typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_CHK, ST_XFER} csr_state_t;
    typedef enum logic [1:0] {RM_DEFAULT, RM_MAIN, RM_BACKUP} csr_rmode_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } csr_cmd_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } csr_rsp_t;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [15:0] data;
    } csr_ram_wr_t;

    typedef struct packed {
        logic start;
        logic store;
        logic [1:0] arr;
        logic [15:0] data;
    } csr_flash_req_t;

endpackage

// [tb/csr_flash_model.sv]
`timescale 1ns/1ps
module csr_flash_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire csr_pkg::csr_flash_req_t req_i,
    input wire logic [7:0] delay_i,
    input wire logic err_mode_i,
    output logic done_o,
    output logic err_o
);
    import csr_pkg::*;
    logic [7:0] cnt_q;
    logic busy_q;
    logic noise_q;
    // delay_i lets one transfer finish before the hold time and another long after
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
            busy_q <= 1'b0;
            done_o <= 1'b0;
            noise_q <= 1'b0;
        end else begin
            noise_q <= ~noise_q;
            done_o <= 1'b0;
            if (req_i.start) begin
                busy_q <= 1'b1;
                cnt_q <= delay_i;
            end else if (busy_q && cnt_q == 8'h00) begin
                busy_q <= 1'b0;
                done_o <= 1'b1;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
    // error only valid beside done; toggles otherwise so nobody leans on it
    assign err_o = done_o ? err_mode_i : noise_q;
endmodule // csr_flash_model

// [tb/testbench.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
    import csr_pkg::*;
    localparam int PC = 8;
    typedef struct packed {logic w; logic [7:0] c; logic [15:0] d;
        logic rv; logic [15:0] rd; logic wv;} csr_row_t;
    logic clk_i, rst_n_i, ce_i, flash_done_i, flash_err_i, main_ok_i, backup_ok_i;
    logic alert_en_i, err_mode, cmd_ready_o, alert_o, cml_o, monitor_hold_o;
    logic null_state_o, fault_pin_n_o;
    logic [7:0] delay, cml_detail_o;
    logic [15:0] crc_main_i, crc_backup_i, crc_ram_i;
    logic [NUM_FAULTS-1:0] fault_event_i, status_fault_o;
    csr_cmd_t cmd_i;
    csr_rsp_t rsp_o;
    csr_ram_wr_t ram_wr_o;
    csr_flash_req_t flash_req_o;
    wire [3:0] req_sum = {flash_req_o.start, flash_req_o.store, flash_req_o.arr};
    int num_errors = 0;
    int samples_checked = 0;
    int n;
    csr_row_t rows [23] = '{
        '{0, 8'hFE, 16'h0000, 1, 16'hFFFF, 0}, '{0, 8'hFC, 16'h0000, 1, 16'h0000, 0},
        '{0, 8'h10, 16'h0000, 1, 16'h0000, 0}, '{1, 8'h10, 16'h0080, 0, 16'h0000, 1},
        '{1, 8'h01, 16'h0080, 0, 16'h0000, 0}, '{1, 8'h00, 16'h0003, 0, 16'h0000, 0},
        '{0, 8'h10, 16'h0000, 1, 16'h0080, 0}, '{1, 8'h10, 16'h0040, 0, 16'h0000, 1},
        '{1, 8'h01, 16'h0080, 0, 16'h0000, 1}, '{1, 8'h00, 16'h0002, 0, 16'h0000, 1},
        '{1, 8'h02, 16'h0017, 0, 16'h0000, 0}, '{1, 8'h10, 16'h0020, 0, 16'h0000, 1},
        '{1, 8'h02, 16'h0017, 0, 16'h0000, 1}, '{1, 8'h21, 16'h1234, 0, 16'h0000, 0},
        '{1, 8'h10, 16'h0000, 0, 16'h0000, 1}, '{1, 8'h21, 16'h1234, 0, 16'h0000, 1},
        '{1, 8'hFE, 16'h0001, 0, 16'h0000, 0}, '{0, 8'hFE, 16'h0000, 1, 16'hB0B0, 0},
        '{1, 8'hFE, 16'h0002, 0, 16'h0000, 0}, '{0, 8'hFE, 16'h0000, 1, 16'hCAFE, 0},
        '{1, 8'hFE, 16'h0000, 0, 16'h0000, 0}, '{0, 8'hFE, 16'h0000, 1, 16'hA5A5, 0},
        '{0, 8'h21, 16'h0000, 1, 16'h0000, 0}};

    csr_engine #(.PROG_CYCLES(16'(PC))) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .ce_i(ce_i), .cmd_i(cmd_i), .rsp_o(rsp_o), .cmd_ready_o(cmd_ready_o),
        .ram_wr_o(ram_wr_o), .flash_req_o(flash_req_o), .flash_done_i(flash_done_i),
        .flash_err_i(flash_err_i), .main_ok_i(main_ok_i), .backup_ok_i(backup_ok_i),
        .crc_main_i(crc_main_i), .crc_backup_i(crc_backup_i), .crc_ram_i(crc_ram_i),
        .fault_event_i(fault_event_i), .alert_en_i(alert_en_i),
        .status_fault_o(status_fault_o), .alert_o(alert_o), .cml_o(cml_o),
        .cml_detail_o(cml_detail_o), .monitor_hold_o(monitor_hold_o),
        .null_state_o(null_state_o), .fault_pin_n_o(fault_pin_n_o));
    csr_flash_model u_flash (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(flash_req_o),
        .delay_i(delay), .err_mode_i(err_mode), .done_o(flash_done_i), .err_o(flash_err_i));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wait_ready(output int k);
        k = 0;
        while (cmd_ready_o !== 1'b1 && k < 500) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        if (k >= 500) `CHK(cmd_ready_o, 1'b1)
    endtask

    // request held until the edge that takes it, outputs read just after that edge
    task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
        int k;
        @(posedge clk_i);
        #1;
        wait_ready(k);
        cmd_i = '{1'b1, w, c, d};
        @(posedge clk_i);
        #1;
        cmd_i.valid = 1'b0;
    endtask

    task automatic reboot(input logic m, input logic b);
        main_ok_i = m;
        backup_ok_i = b;
        rst_n_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        `CHK({cmd_ready_o, monitor_hold_o, fault_pin_n_o, null_state_o}, 4'h6)
        rst_n_i = 1'b1;
    endtask

    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end

    initial begin
        ce_i = 1'b1;
        cmd_i = '0;
        alert_en_i = 1'b1;
        err_mode = 1'b0;
        delay = 8'h03;
        fault_event_i = '0;
        crc_main_i = 16'hA5A5;
        crc_backup_i = 16'hB0B0;
        crc_ram_i = 16'hCAFE;
        reboot(1'b1, 1'b1);
        wait_ready(n);
        `CHK(n, PC + 2)
        foreach (rows[i]) begin
            cmd(rows[i].w, rows[i].c, rows[i].d);
            `CHK(rsp_o.valid, rows[i].rv)
            if (rows[i].rv) `CHK(rsp_o.data, rows[i].rd)
            `CHK(ram_wr_o.valid, rows[i].wv)
            if (rows[i].wv) `CHK(ram_wr_o[23:0], {rows[i].c, rows[i].d})
            `CHK({flash_req_o.start, cml_o}, 2'b00)
        end
        delay = 8'h14;
        cmd(1'b1, CMD_STORE_DEFAULT, 16'h0000);
        `CHK(req_sum, {2'b11, ARR_MAIN})
        `CHK({cmd_ready_o, monitor_hold_o}, 2'b01)
        wait_ready(n);
        // late done: ready follows the done pulse by one edge
        `CHK(n, int'(delay) + 3)
        `CHK({monitor_hold_o, cml_o}, 2'b00)
        delay = 8'h03;
        err_mode = 1'b1;
        cmd(1'b1, CMD_VENDOR_STORE_ALL, 16'h0001);
        `CHK(req_sum, {2'b11, ARR_BACKUP})
        wait_ready(n);
        err_mode = 1'b0;
        // early done: the programming hold alone sets the length
        `CHK(n, PC)
        `CHK({cml_o, alert_o, cml_detail_o}, 10'h300)
        cmd(1'b1, CMD_VENDOR_STORE_ALL, 16'h0005);
        `CHK({flash_req_o.start, cmd_ready_o}, 2'b01)
        cmd(1'b1, CMD_VENDOR_RESTORE_ALL, 16'h0002);
        @(posedge clk_i);
        #1;
        `CHK({flash_req_o.start, cmd_ready_o}, 2'b01)
        cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
        `CHK({cml_o, alert_o, ram_wr_o.valid}, 3'b000)
        // restores are only issued here with no supplies running
        cmd(1'b1, CMD_VENDOR_RESTORE_ALL, 16'h0001);
        @(posedge clk_i);
        #1;
        `CHK(req_sum, {2'b10, ARR_BACKUP})
        main_ok_i = 1'b0;
        cmd(1'b1, CMD_VENDOR_RESTORE_ALL, 16'h0000);
        wait_ready(n);
        `CHK({null_state_o, cml_detail_o}, 9'h002)
        cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
        main_ok_i = 1'b1;
        backup_ok_i = 1'b0;
        cmd(1'b1, CMD_VENDOR_RESTORE_ALL, 16'h0001);
        wait_ready(n);
        `CHK({null_state_o, cml_detail_o}, 9'h004)
        cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
        main_ok_i = 1'b0;
        backup_ok_i = 1'b1;
        cmd(1'b1, CMD_RESTORE_DEFAULT, 16'h0000);
        @(posedge clk_i);
        #1;
        `CHK({flash_req_o.start, flash_req_o.arr}, {1'b1, ARR_BACKUP})
        wait_ready(n);
        `CHK({null_state_o, cml_detail_o}, 9'h002)
        main_ok_i = 1'b1;
        cmd(1'b1, CMD_VENDOR_RESTORE_ALL, 16'h0000);
        @(posedge clk_i);
        #1;
        `CHK(req_sum, {2'b10, ARR_MAIN})
        wait_ready(n);
        fault_event_i = 8'h01;
        repeat (2) @(posedge clk_i);
        #1;
        `CHK({alert_o, status_fault_o[0]}, 2'b11)
        cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
        repeat (2) @(posedge clk_i);
        #1;
        `CHK({alert_o, status_fault_o}, 9'h001)
        fault_event_i = 8'h03;
        repeat (2) @(posedge clk_i);
        #1;
        `CHK({alert_o, status_fault_o[1]}, 2'b11)
        fault_event_i = 8'h00;
        cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
        @(posedge clk_i);
        #1;
        `CHK({alert_o, status_fault_o}, 9'h000)
        // frozen by the clock enable, the new fault shows only once it runs again
        ce_i = 1'b0;
        fault_event_i = 8'h04;
        repeat (2) @(posedge clk_i);
        #1;
        `CHK({alert_o, status_fault_o}, 9'h000)
        ce_i = 1'b1;
        @(posedge clk_i);
        #1;
        `CHK({alert_o, status_fault_o}, 9'h104)
        fault_event_i = 8'h00;
        // one single store only, far below the host's limit
        cmd(1'b1, CMD_SINGLE_PARAM_STORE, 16'h0460);
        `CHK({flash_req_o.start, flash_req_o.arr}, {1'b1, ARR_SINGLE})
        `CHK({flash_req_o.data, monitor_hold_o}, {16'h0460, 1'b0})
        cmd(1'b0, CMD_SINGLE_PARAM_STORE, 16'h0000);
        `CHK(rsp_o.data, 16'h0460)
        reboot(1'b0, 1'b0);
        repeat (4) @(posedge clk_i);
        #1;
        `CHK({null_state_o, fault_pin_n_o, cml_detail_o}, 10'h206)
        cmd(1'b0, CMD_CRC_REPORT, 16'h0000);
        `CHK({rsp_o.valid, rsp_o.data}, 17'h1FFFF)
        wrap_up();
    end
endmodule // testbench
